//--- hdl/arith_datapath_defines.vh
// Purpose: constants shared by the arithmetic datapath
// Assumes: included by bare name from the datapath module
// Notes:   register indices are word addresses on the plain register port
`ifndef ARITH_DATAPATH_DEFINES_VH
`define ARITH_DATAPATH_DEFINES_VH

// register port word addresses
`define REG_STATUS_ZERO     4'h0
`define REG_STATUS_ONE      4'h1
`define REG_ACC_HIGH        4'h2
`define REG_ACC_LOW         4'h3
`define REG_PROD_HIGH       4'h4
`define REG_PROD_LOW        4'h5
`define REG_MULTIPLICAND    4'h6
`define REG_POINTER         4'h7

// status word zero: pointer select field
`define PSF_MSB             15
`define PSF_LSB             13
// status word one: sign extend select and product shift select
`define SXM_BIT             10
`define PM_MSB              1
`define PM_LSB              0

// status reset values
`define STATUS_ZERO_RST     16'h0000
`define STATUS_ONE_RST      16'h0000

// product shift modes
`define PM_NONE             2'h0
`define PM_LEFT1            2'h1
`define PM_LEFT4            2'h2
`define PM_RIGHT6           2'h3
`define PM_LEFT4_AMT        4
`define PM_RIGHT6_AMT       6

// central alu operations
`define ALU_LOAD            3'h0
`define ALU_ADD             3'h1
`define ALU_SUB             3'h2
`define ALU_AND             3'h3
`define ALU_OR              3'h4
`define ALU_XOR             3'h5
`define ALU_NOT             3'h6

// store source selects
`define ST_ACC_LOW          2'h0
`define ST_ACC_HIGH         2'h1
`define ST_POINTER          2'h2
`define ST_PROD_LOW         2'h3

// input shift limit
`define IN_SHIFT_MAX        5'h10

`endif

//--- hdl/arith_datapath.v
// Purpose: arithmetic datapath: input shifter, central alu, accumulator,
//          output shifter, multiplier, product shifter, pointer unit
// Assumes: one 100 MHz clock, synchronous active-low reset, the decoder
//          drives one-cycle command strobes
// Notes:   status words live behind the plain register port
//
// Notes on behaviour
// - alu works 32-bit two's complement on shifted operand or product
// - alu also does bitwise and, or, xor and not
// - accumulator takes the alu result on each alu_en_i strobe and is the alu's first operand
// - accumulator is 32 bits; high and low halves stored separately
// - output shifter shifts accumulator left 0..7, accumulator kept intact
// - product shifter: none, left one, left four or right six
// - multiplier forms signed 32-bit result from two signed 16-bit words
// - one factor is the multiplicand register; product goes to product register
// - a multiply completes in one clock cycle
// - eight 16-bit pointers give indirect addresses; load and store them
// - 3-bit field in status word zero picks the current pointer
// - input shifter takes 16 bits from data or program read bus
// - input shifter shifts left 0..16, 32-bit result to alu
// - low bits zero filled; high bits zero or sign per select bit
// - input shift count from instruction or multiplicand low four bits
// - sign extend select is status word one bit 10
// - input shifter is combinational, no added cycle
// - two-bit product shift select in status word one, codes 00..11
// - right six always sign extends; product register itself unchanged
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "arith_datapath_defines.vh"

module arith_datapath (
    // clock and reset
    input  wire        clk_i,
    input  wire        resetn_i,
    // register port
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_we_i,
    input  wire        reg_re_i,
    output wire [15:0] reg_rdata_o,
    // memory buses
    input  wire [15:0] data_read_bus_i,
    input  wire [15:0] program_read_bus_i,
    // input shifter control
    input  wire        in_src_prog_i,
    input  wire        shift_src_multiplicand_holding_reg_i,
    input  wire [4:0]  shift_imm_i,
    // central alu control
    input  wire        alu_en_i,
    input  wire [2:0]  alu_op_i,
    input  wire        alu_b_prod_i,
    // multiplier control
    input  wire        multiplicand_holding_reg_load_i,
    input  wire        mpy_en_i,
    input  wire        mpy_src_prog_i,
    // pointer unit control
    input  wire        ptr_load_i,
    input  wire        ptr_load_prog_i,
    input  wire        ptr_inc_i,
    input  wire        ptr_dec_i,
    input  wire        ptr_sel_load_i,
    input  wire [2:0]  ptr_sel_i,
    // store control
    input  wire        store_en_i,
    input  wire [1:0]  store_src_i,
    input  wire [2:0]  out_shift_i,
    // outputs
    output wire [15:0] data_addr_o,
    output wire [15:0] store_data_o,
    output wire        store_valid_o,
    output wire [31:0] acc_o
);

    // state
    reg [15:0] status_zero_ff;
    reg [15:0] status_one_ff;
    reg [31:0] acc_ff;
    reg [31:0] prod_ff;
    reg [15:0] multiplicand_holding_reg_ff;
    reg [15:0] ptr_ff [0:7];
    reg [15:0] store_data_ff;
    reg        store_valid_ff;
    reg [15:0] rdata_ff;

    // combinational
    reg  [31:0] in_shifted;
    reg  [31:0] prod_shifted;
    reg  [31:0] nxt_acc;
    reg  [31:0] alu_b;
    reg  [15:0] nxt_store;
    reg  [15:0] nxt_rdata;
    reg  [4:0]  in_cnt;
    wire [15:0] in_word;
    wire [15:0] mpy_word;
    wire [31:0] product;
    wire [31:0] out_shifted;
    wire [2:0]  psel;
    wire        sign_extend_select;
    wire [1:0]  pm;
    integer     i;

    // status field taps
    assign psel = status_zero_ff[`PSF_MSB:`PSF_LSB];
    assign sign_extend_select  = status_one_ff[`SXM_BIT];
    assign pm   = status_one_ff[`PM_MSB:`PM_LSB];

    // operand source for the input shifter
    assign in_word = in_src_prog_i ? program_read_bus_i : data_read_bus_i;

    // input shifter count; counts past sixteen clamp to sixteen
    always @* begin
        if (shift_src_multiplicand_holding_reg_i)
            in_cnt = {1'b0, multiplicand_holding_reg_ff[3:0]};
        else if (shift_imm_i > `IN_SHIFT_MAX)
            in_cnt = `IN_SHIFT_MAX;
        else
            in_cnt = shift_imm_i;
    end

    // input shifter; pure logic so it costs no cycle
    always @* begin
        if (sign_extend_select)
            in_shifted = {{16{in_word[15]}}, in_word} << in_cnt;
        else
            in_shifted = {16'h0000, in_word} << in_cnt;
    end

    // product shifter works on a copy; product register never moves
    always @* begin
        case (pm)
            `PM_NONE:   prod_shifted = prod_ff;
            `PM_LEFT1:  prod_shifted = {prod_ff[30:0], 1'b0};
            `PM_LEFT4:  prod_shifted = prod_ff << `PM_LEFT4_AMT;
            `PM_RIGHT6: prod_shifted = $signed(prod_ff) >>> `PM_RIGHT6_AMT;
            default:    prod_shifted = prod_ff;
        endcase
    end

    // central alu: accumulator is operand a, shifter output operand b
    always @* begin
        alu_b = alu_b_prod_i ? prod_shifted : in_shifted;
        case (alu_op_i)
            `ALU_LOAD: nxt_acc = alu_b;
            `ALU_ADD:  nxt_acc = acc_ff + alu_b;
            `ALU_SUB:  nxt_acc = acc_ff - alu_b;
            `ALU_AND:  nxt_acc = acc_ff & alu_b;
            `ALU_OR:   nxt_acc = acc_ff | alu_b;
            `ALU_XOR:  nxt_acc = acc_ff ^ alu_b;
            `ALU_NOT:  nxt_acc = ~acc_ff;
            default:   nxt_acc = acc_ff;
        endcase
    end

    // multiplier: second factor from data or program bus
    assign mpy_word = mpy_src_prog_i ? program_read_bus_i : data_read_bus_i;
    assign product  = $signed(multiplicand_holding_reg_ff) * $signed(mpy_word);

    // output shifter: a shifted copy, bits past the word are dropped
    assign out_shifted = acc_ff << out_shift_i;

    // store data select
    always @* begin
        case (store_src_i)
            `ST_ACC_LOW:  nxt_store = out_shifted[15:0];
            `ST_ACC_HIGH: nxt_store = out_shifted[31:16];
            `ST_POINTER:  nxt_store = ptr_ff[psel];
            `ST_PROD_LOW: nxt_store = prod_shifted[15:0];
            default:      nxt_store = out_shifted[15:0];
        endcase
    end

    // register read mux; unmapped words read as zero
    always @* begin
        case (reg_addr_i)
            `REG_STATUS_ZERO:  nxt_rdata = status_zero_ff;
            `REG_STATUS_ONE:   nxt_rdata = status_one_ff;
            `REG_ACC_HIGH:     nxt_rdata = acc_ff[31:16];
            `REG_ACC_LOW:      nxt_rdata = acc_ff[15:0];
            `REG_PROD_HIGH:    nxt_rdata = prod_ff[31:16];
            `REG_PROD_LOW:     nxt_rdata = prod_ff[15:0];
            `REG_MULTIPLICAND: nxt_rdata = multiplicand_holding_reg_ff;
            `REG_POINTER:      nxt_rdata = ptr_ff[psel];
            default:           nxt_rdata = 16'h0000;
        endcase
    end

    // status words; the decoder's select load beats a same-cycle write
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            status_zero_ff <= `STATUS_ZERO_RST;
            status_one_ff  <= `STATUS_ONE_RST;
        end else begin
            if (ptr_sel_load_i)
                status_zero_ff[`PSF_MSB:`PSF_LSB] <= ptr_sel_i;
            else if (reg_we_i && reg_addr_i == `REG_STATUS_ZERO)
                status_zero_ff <= reg_wdata_i;
            if (reg_we_i && reg_addr_i == `REG_STATUS_ONE)
                status_one_ff <= reg_wdata_i;
        end
    end

    // accumulator takes the alu result only when alu_en_i is set
    always @(posedge clk_i) begin
        if (!resetn_i)
            acc_ff <= 32'h00000000;
        else if (alu_en_i)
            acc_ff <= nxt_acc;
    end

    // multiplicand and product; product lands the cycle after the strobe
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            multiplicand_holding_reg_ff <= 16'h0000;
            prod_ff <= 32'h00000000;
        end else begin
            if (multiplicand_holding_reg_load_i)
                multiplicand_holding_reg_ff <= data_read_bus_i;
            if (mpy_en_i)
                prod_ff <= product;
        end
    end

    // pointer registers; a load wins over a step on the same pointer
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 8; i = i + 1)
                ptr_ff[i] <= 16'h0000;
        end else if (ptr_load_i) begin
            ptr_ff[psel] <= ptr_load_prog_i ? program_read_bus_i
                                            : data_read_bus_i;
        end else if (ptr_inc_i) begin
            ptr_ff[psel] <= ptr_ff[psel] + 16'h0001;
        end else if (ptr_dec_i) begin
            ptr_ff[psel] <= ptr_ff[psel] - 16'h0001;
        end
    end

    // store word and register read data, both one cycle late
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            store_data_ff  <= 16'h0000;
            store_valid_ff <= 1'b0;
            rdata_ff       <= 16'h0000;
        end else begin
            store_valid_ff <= store_en_i;
            if (store_en_i)
                store_data_ff <= nxt_store;
            if (reg_re_i)
                rdata_ff <= nxt_rdata;
        end
    end

    // outputs
    assign data_addr_o   = ptr_ff[psel];
    assign store_data_o  = store_data_ff;
    assign store_valid_o = store_valid_ff;
    assign reg_rdata_o   = rdata_ff;
    assign acc_o         = acc_ff;

endmodule // arith_datapath

//--- dv/arith_datapath_sva.sv
// Purpose: assertions on the arithmetic datapath ports
// Assumes: bound to the datapath top, one clock domain
// Notes:   store and read checks use values sampled at the request edge
`timescale 1ns/10ps
module arith_datapath_sva (
    // clock, reset, register port
    input wire logic        clk_i, resetn_i, reg_re_i, reg_we_i,
    input wire logic [3:0]  reg_addr_i,
    // commands
    input wire logic        alu_en_i, ptr_load_i, ptr_inc_i, ptr_dec_i,
    input wire logic        ptr_sel_load_i, store_en_i,
    input wire logic [2:0]  ptr_sel_i, out_shift_i,
    input wire logic [1:0]  store_src_i,
    // outputs
    input wire logic [15:0] reg_rdata_o, data_addr_o, store_data_o,
    input wire logic        store_valid_o,
    input wire logic [31:0] acc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // accumulator copy as the store path should see it
    wire [31:0] acc_shl = acc_o << out_shift_i;
    wire        ptr_busy = ptr_load_i | ptr_inc_i | ptr_dec_i | ptr_sel_load_i | reg_we_i;

    store_pulse_a: assert property (1 |=> store_valid_o == $past(store_en_i))
        else $error("store valid not one cycle after store");
    store_low_a: assert property (store_en_i && store_src_i == 2'h0 |=>
        store_data_o == $past(acc_shl[15:0])) else $error("low store word wrong");
    store_high_a: assert property (store_en_i && store_src_i == 2'h1 |=>
        store_data_o == $past(acc_shl[31:16])) else $error("high store word wrong");
    acc_kept_a: assert property (!alu_en_i |=> $stable(acc_o))
        else $error("accumulator moved without alu command");
    read_acc_a: assert property (reg_re_i && reg_addr_i == 4'h2 |=>
        reg_rdata_o == $past(acc_o[31:16])) else $error("accumulator high read wrong");
    ptr_sel_a: assert property (ptr_sel_load_i ##1 reg_re_i && reg_addr_i == 4'h0 |=>
        reg_rdata_o[15:13] == $past(ptr_sel_i, 2)) else $error("pointer field wrong");
    ptr_step_a: assert property (ptr_inc_i && !(ptr_load_i | ptr_sel_load_i | reg_we_i) |=>
        data_addr_o == $past(data_addr_o) + 16'h0001) else $error("pointer step wrong");
    ptr_hold_a: assert property (!ptr_busy |=> $stable(data_addr_o))
        else $error("address moved without pointer command");
    // main scenarios reached
    cover property (store_en_i ##1 store_en_i);
    cover property (ptr_sel_load_i ##1 reg_re_i);
    cover property (alu_en_i && ptr_inc_i == 1'b0);
endmodule // arith_datapath_sva

//--- dv/data_mem_model.sv
// Purpose: data memory at the far side of the datapath
// Assumes: operand read is combinational on the pointer address
// Notes:   eight words, upper address bits ignored
`timescale 1ns/10ps
module data_mem_model (
    // clock and datapath side
    input  wire logic        clk_i, we_i,
    input  wire logic [15:0] addr_i, wdata_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [0:7];
    // known contents so a multiplicand load from word 0 gives 3
    initial begin
        for (int i = 0; i < 8; i++) begin
            mem[i] = 16'h0003 + 16'(i);
        end
    end
    // operand fetch needs no extra cycle
    assign rdata_o = mem[addr_i[2:0]];
    // stores land at the edge that closes the store-valid cycle
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i[2:0]] <= wdata_i;
        end
    end
endmodule // data_mem_model

//--- dv/testbench.sv
// Purpose: self-checking bench for the arithmetic datapath
// Assumes: one packed control word holds all decoder strobes of a cycle
// Notes:   table rows cover shifter and alu, the rest is written by hand
`timescale 1ns/10ps
module testbench;
    // stimulus state, zero at time zero
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [35:0] ctl = '0;
    logic [4:0]  shift_imm_i = '0;
    logic [15:0] dat = '0;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // design nets
    wire [3:0]  reg_addr_i;
    wire [2:0]  alu_op_i, ptr_sel_i, out_shift_i;
    wire [1:0]  store_src_i;
    wire [15:0] reg_wdata_i, program_read_bus_i, data_read_bus_i;
    wire [15:0] reg_rdata_o, data_addr_o, store_data_o;
    wire [31:0] acc_o;
    wire        reg_we_i, reg_re_i, alu_en_i, alu_b_prod_i, in_src_prog_i, shift_src_multiplicand_holding_reg_i;
    wire        multiplicand_holding_reg_load_i, mpy_en_i, mpy_src_prog_i, ptr_load_i, ptr_load_prog_i;
    wire        ptr_inc_i, ptr_dec_i, ptr_sel_load_i, store_en_i, store_valid_o;
    // sign select, alu op, shift, constant, expected accumulator
    logic [56:0] rows [11] = '{
        {1'b0, 3'h0, 5'h08, 16'h8234, 32'h00823400}, {1'b1, 3'h0, 5'h08, 16'h8234, 32'hFF823400},
        {1'b1, 3'h0, 5'h10, 16'h8001, 32'h80010000}, {1'b0, 3'h1, 5'h00, 16'hFFFF, 32'h8001FFFF},
        {1'b1, 3'h1, 5'h00, 16'h0001, 32'h80020000}, {1'b1, 3'h2, 5'h04, 16'h0001, 32'h8001FFF0},
        {1'b0, 3'h3, 5'h00, 16'h0F0F, 32'h00000F00}, {1'b0, 3'h4, 5'h1F, 16'h1234, 32'h12340F00},
        {1'b0, 3'h5, 5'h00, 16'hFFFF, 32'h1234F0FF}, {1'b0, 3'h6, 5'h00, 16'h0000, 32'hEDCB0F00},
        {1'b0, 3'h7, 5'h00, 16'h1234, 32'hEDCB0F00}};
    // accumulator per product shift code, the product being -6
    logic [31:0] pm_exp [4] = '{32'hFFFFFFFA, 32'hFFFFFFF4, 32'hFFFFFFA0, 32'hFFFFFFFF};

    // the control word fans out to strobes and selects
    // one fixed bit per strobe, matching the hex words used below
    assign reg_addr_i       = ctl[35:32];
    assign alu_en_i         = ctl[31];
    assign alu_op_i         = ctl[30:28];
    assign alu_b_prod_i     = ctl[27];
    assign in_src_prog_i    = ctl[26];
    assign shift_src_multiplicand_holding_reg_i = ctl[25];
    assign multiplicand_holding_reg_load_i      = ctl[24];
    assign mpy_en_i         = ctl[23];
    assign mpy_src_prog_i   = ctl[22];
    assign ptr_load_i       = ctl[21];
    assign ptr_load_prog_i  = ctl[20];
    assign store_en_i       = ctl[16];
    assign ptr_inc_i        = ctl[15];
    assign ptr_dec_i        = ctl[14];
    assign ptr_sel_load_i   = ctl[13];
    assign reg_we_i         = ctl[11];
    assign reg_re_i         = ctl[10];
    assign store_src_i      = ctl[9:8];
    assign out_shift_i = ctl[6:4];
    assign ptr_sel_i = ctl[2:0];
    assign program_read_bus_i = dat;
    assign reg_wdata_i = dat;

    arith_datapath dut (.*);
    data_mem_model mem_u (.clk_i(clk_i), .we_i(store_valid_o), .addr_i(data_addr_o),
                          .wdata_i(store_data_o), .rdata_o(data_read_bus_i));

    // one cycle of stimulus; checks after it see that edge's updates
    task automatic cyc(input logic [35:0] c, input logic [4:0] s, input logic [15:0] d);
        @(posedge clk_i);
        ctl <= c;
        shift_imm_i <= s;
        dat <= d;
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        cyc({a, 32'h00000800}, 5'h00, d);
    endtask
    // read data are looked at only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        cyc({a, 32'h00000400}, 5'h00, 16'h0000);
        cyc(0, 0, 0);
        chk(reg_rdata_o, e);
    endtask
    task automatic stop_test;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // free-running clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard far above the roughly one hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 2000) begin
            fail_count++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        chk(acc_o, 0);
        chk({store_valid_o, data_addr_o}, 0);
        foreach (rows[i]) begin
            wr(4'h1, {5'h00, rows[i][56], 10'h000});
            cyc({5'h01, rows[i][55:53], 4'h4, 24'h0}, rows[i][52:48], rows[i][47:32]);
            cyc(0, 0, 0);
            chk(acc_o, rows[i][31:0]);
        end
        // multiplicand from memory word 0, product next cycle
        cyc(36'h001000000, 0, 0);
        cyc(36'h000C00000, 0, 16'hFFFE);
        for (int m = 0; m < 4; m++) begin
            wr(4'h1, 16'(m));
            cyc(36'h088000000, 0, 0);
            cyc(0, 0, 0);
            chk(acc_o, pm_exp[m]);
        end
        rd(4'h5, 16'hFFFA);
        // shift count from multiplicand low bits, immediate ignored
        cyc(36'h086000000, 5'h10, 16'hF001);
        cyc(0, 0, 0);
        chk(acc_o, 32'h00078008);
        // back-to-back stores of both halves shifted by seven
        cyc(36'h000010070, 0, 0);
        cyc(36'h000010170, 0, 0);
        chk({store_valid_o, store_data_o}, 32'h00010400);
        cyc(0, 0, 0);
        chk(store_data_o, 16'h03C0);
        chk(acc_o, 32'h00078008);
        // the stored word returns on the data bus
        cyc(0, 0, 0);
        cyc(36'h080000000, 0, 0);
        cyc(0, 0, 0);
        chk(acc_o, 32'h000003C0);
        // select pointer 7, load it from the program bus, step it
        cyc(36'h000002007, 0, 0);
        rd(4'h0, 16'hE000);
        cyc(36'h000300000, 0, 16'h0005);
        cyc(36'h000008000, 0, 0);
        rd(4'h7, 16'h0006);
        // store the selected pointer, then step it down
        cyc(36'h000010200, 0, 0);
        cyc(36'h000004000, 0, 0);
        chk(store_data_o, 16'h0006);
        rd(4'h7, 16'h0005);
        wr(4'h0, 16'h0000);
        cyc(0, 0, 0);
        chk(data_addr_o, 16'h0000);
        // read-only and unmapped places
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h03C0);
        rd(4'h9, 16'h0000);
        stop_test();
    end
endmodule // testbench

bind arith_datapath arith_datapath_sva u_sva (.*);
